/* core/pvfc_codec.sv */
// parameter value format checker and time/percent decoder
`timescale 1ns/1ps
module pvfc_codec
   import pvfc_pkg::*;
#(
   parameter int BASE_W = 32
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              reset,
   // job strobe and contents
   input  wire logic              job_valid,
   input  wire logic [7:0]        job_format,
   input  wire logic [2:0]        job_value_bytes,
   input  wire logic [31:0]       job_value,
   input  wire logic [7:0]        param_type,
   // scan time base, the content of parameter_index 962
   input  wire logic [BASE_W-1:0] scan_time_base,
   // results
   output logic                   result_valid,
   output logic                   format_ok,
   output logic [7:0]             fault_code,
   output logic [2:0]             format_length,
   output logic                   sign_flag,
   output logic [15:0]            norm_percent_16,
   output logic [15:0]            packed_bool_word,
   output logic [63:0]            time_value
);

   // length lookup per format, zero bytes for unsupported
   logic       code_known;
   logic [2:0] code_len;

   // format table, a flat decode keeps it one level of logic
   always_comb begin
      code_known = 1'b1;
      code_len   = 3'h0;
      unique case (job_format)
         // one-byte formats
         FMT_UINT8, FMT_BYTE, FMT_OCTETS: code_len = 3'h1;
         // two-byte formats; fractional time uses all sixteen value bits
         FMT_INT16, FMT_UINT16, FMT_WORD, FMT_ERROR, FMT_NORM_PERCENT,
         FMT_PACKED_BOOL, FMT_INT_TIME_16, FMT_FRAC_TIME: code_len = 3'h2;
         // four-byte formats
         FMT_UINT32, FMT_DWORD, FMT_TIME_DIFF, FMT_INT_TIME_32: code_len = 3'h4;
         // zero format carries no value bytes
         FMT_ZERO: code_len = 3'h0;
         // anything else is unsupported
         default: code_known = 1'b0;
      endcase
   end

   // next values of all result flops
   logic        next_result_valid;
   logic        next_format_ok;
   logic [7:0]  next_fault_code;
   logic [2:0]  next_format_length;
   logic        next_sign_flag;
   logic [15:0] next_norm_percent_16;
   logic [15:0] next_packed_bool_word;
   logic [63:0] next_time_value;
   logic [63:0] product;               // full 32-bit value times base
   logic [63:0] product_16;            // low 16 value bits times base

   // decode of one job into its interpreted value
   always_comb begin
      next_result_valid     = job_valid;
      next_format_ok        = format_ok;
      next_fault_code       = fault_code;
      next_format_length    = format_length;
      next_sign_flag        = sign_flag;
      next_norm_percent_16  = norm_percent_16;
      next_packed_bool_word = packed_bool_word;
      next_time_value       = time_value;
      // single fixed base for all time formats
      product = 64'(job_value) * 64'(scan_time_base);
      // two-byte formats ignore whatever sits on the upper value lines
      product_16 = 64'(job_value[15:0]) * 64'(scan_time_base);
      if (job_valid) begin
         next_format_length = code_len;
         // unknown, mismatched or wrong-length value gives fault five
         next_format_ok  = code_known && (job_format == param_type) && (job_value_bytes == code_len);
         next_fault_code = next_format_ok ? FAULT_NONE : FAULT_DATA_TYPE;
         if (next_format_ok) begin
            unique case (job_format)
               // raw 16384 is one hundred percent
               // bit 15 is the sign, two's complement kept
               FMT_NORM_PERCENT: begin
                  next_norm_percent_16 = job_value[15:0];
                  next_sign_flag       = job_value[NORM_SIGN_BIT];
               end
               FMT_PACKED_BOOL: next_packed_bool_word = {job_value[15:8], job_value[7:0]};
               FMT_FRAC_TIME: next_time_value = product_16 >> FRAC_TIME_SHIFT;
               FMT_INT_TIME_16: next_time_value = product_16;
               FMT_INT_TIME_32: next_time_value = product;
               // resolution two to minus 31 of base, kept as fixed point
               FMT_TIME_DIFF: next_time_value = product;
               default: next_time_value = time_value;
            endcase
         end
      end
   end

   // result registers
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         result_valid     <= 1'b0;
         format_ok        <= 1'b0;
         fault_code       <= FAULT_NONE;
         format_length    <= 3'h0;
         sign_flag        <= 1'b0;
         norm_percent_16  <= 16'h0000;
         packed_bool_word <= 16'h0000;
         time_value       <= 64'h0000_0000_0000_0000;
      end else begin
         result_valid     <= next_result_valid;
         format_ok        <= next_format_ok;
         fault_code       <= next_fault_code;
         format_length    <= next_format_length;
         sign_flag        <= next_sign_flag;
         norm_percent_16  <= next_norm_percent_16;
         packed_bool_word <= next_packed_bool_word;
         time_value       <= next_time_value;
      end
   end

   // checks on the answer strobe and the verdict
   // answer one cycle after job
   AST_RESULT_PULSE: assert property (@(posedge mclk) disable iff (reset)
      job_valid |=> result_valid)
      else $error("job without result strobe");
   AST_RESULT_IDLE: assert property (@(posedge mclk) disable iff (reset)
      !job_valid |=> !result_valid && $stable(format_ok) && $stable(fault_code))
      else $error("result changed without a job");
   AST_UNKNOWN_FAULT: assert property (@(posedge mclk) disable iff (reset)
      job_valid && !code_known |=> !format_ok && fault_code == FAULT_DATA_TYPE)
      else $error("unsupported format accepted");
   AST_ACCEPT: assert property (@(posedge mclk) disable iff (reset)
      job_valid && job_format == FMT_UINT16 && param_type == FMT_UINT16 && job_value_bytes == 3'h2
      |=> format_ok && fault_code == FAULT_NONE)
      else $error("valid job refused");

   // length checks
   // byte count must match
   AST_LEN_FAULT: assert property (@(posedge mclk) disable iff (reset)
      job_valid && job_value_bytes != code_len |=> !format_ok && fault_code == FAULT_DATA_TYPE)
      else $error("byte length mismatch accepted");
   AST_TIME_LEN: assert property (@(posedge mclk) disable iff (reset)
      job_valid && (job_format == FMT_FRAC_TIME || job_format == FMT_INT_TIME_16) |=> format_length == 3'h2)
      else $error("two-byte time length wrong");
   AST_LONG_LEN: assert property (@(posedge mclk) disable iff (reset)
      job_valid && (job_format == FMT_INT_TIME_32 || job_format == FMT_TIME_DIFF) |=> format_length == 3'h4)
      else $error("four-byte time length wrong");

   // type checks
   // mismatch gives fault five
   AST_TYPE_FAULT: assert property (@(posedge mclk) disable iff (reset)
      job_valid && job_format != param_type |=> !format_ok && fault_code == FAULT_DATA_TYPE)
      else $error("type mismatch without fault");
   AST_HOLD_VALUES: assert property (@(posedge mclk) disable iff (reset)
      job_valid && job_format != param_type
      |=> $stable(sign_flag) && $stable(norm_percent_16) && $stable(packed_bool_word) && $stable(time_value))
      else $error("refused job changed a value");
   AST_FAULT_SET: assert property (@(posedge mclk) disable iff (reset)
      fault_code == FAULT_NONE || fault_code == FAULT_DATA_TYPE)
      else $error("unexpected fault code");

   // value decoding
   // sign is bit fifteen
   AST_NORM_SIGN: assert property (@(posedge mclk) disable iff (reset)
      job_valid && job_format == FMT_NORM_PERCENT
      |=> !format_ok || sign_flag == $past(job_value[NORM_SIGN_BIT]))
      else $error("sign flag not bit 15");
   AST_NORM_VALUE: assert property (@(posedge mclk) disable iff (reset)
      job_valid && job_format == FMT_NORM_PERCENT
      |=> !format_ok || norm_percent_16 == $past(job_value[15:0]))
      else $error("normalised value altered");
   AST_NORM_UNIT: assert property (@(posedge mclk) disable iff (reset)
      job_valid && job_format == FMT_NORM_PERCENT && job_value[15:0] == 16'h4000
      |=> !format_ok || (!sign_flag && norm_percent_16 == 16'h4000))
      else $error("hundred percent misplaced");
   AST_BOOL: assert property (@(posedge mclk) disable iff (reset)
      job_valid && job_format == FMT_PACKED_BOOL
      |=> !format_ok || packed_bool_word == $past(job_value[15:0]))
      else $error("packed booleans misordered");
   AST_FRAC: assert property (@(posedge mclk) disable iff (reset)
      job_valid && job_format == FMT_FRAC_TIME
      |=> !format_ok
          || time_value == (64'($past(job_value[15:0])) * 64'($past(scan_time_base))) >> FRAC_TIME_SHIFT)
      else $error("fractional time wrong");
   AST_INT16: assert property (@(posedge mclk) disable iff (reset)
      job_valid && job_format == FMT_INT_TIME_16
      |=> !format_ok || time_value == 64'($past(job_value[15:0])) * 64'($past(scan_time_base)))
      else $error("short integer time wrong");
   AST_INT32: assert property (@(posedge mclk) disable iff (reset)
      job_valid && job_format == FMT_INT_TIME_32
      |=> !format_ok || time_value == 64'($past(job_value)) * 64'($past(scan_time_base)))
      else $error("integer time wrong");
   AST_TDIFF: assert property (@(posedge mclk) disable iff (reset)
      job_valid && job_format == FMT_TIME_DIFF
      |=> !format_ok || time_value == 64'($past(job_value)) * 64'($past(scan_time_base)))
      else $error("time difference wrong");

endmodule : pvfc_codec

/* core/pvfc_pkg.sv */
// package of constants for the parameter value format codec
package pvfc_pkg;
   // job layout
   localparam logic [3:0]  FORMAT_BYTE_POS   = 4'hA;
   localparam logic [15:0] SCAN_TIME_INDEX   = 16'h03C2;
   // format codes accepted by the device
   localparam logic [7:0]  FMT_INT16         = 8'h03;
   localparam logic [7:0]  FMT_UINT8         = 8'h05;
   localparam logic [7:0]  FMT_UINT16        = 8'h06;
   localparam logic [7:0]  FMT_UINT32        = 8'h07;
   localparam logic [7:0]  FMT_OCTETS        = 8'h0A;
   localparam logic [7:0]  FMT_TIME_DIFF     = 8'h0D;
   localparam logic [7:0]  FMT_ZERO          = 8'h40;
   localparam logic [7:0]  FMT_BYTE          = 8'h41;
   localparam logic [7:0]  FMT_WORD          = 8'h42;
   localparam logic [7:0]  FMT_DWORD         = 8'h43;
   localparam logic [7:0]  FMT_ERROR         = 8'h44;
   localparam logic [7:0]  FMT_NORM_PERCENT  = 8'h71;
   localparam logic [7:0]  FMT_PACKED_BOOL   = 8'h73;
   localparam logic [7:0]  FMT_INT_TIME_16   = 8'h76;
   localparam logic [7:0]  FMT_INT_TIME_32   = 8'h77;
   localparam logic [7:0]  FMT_FRAC_TIME     = 8'h78;
   // normalised value layout
   localparam int          NORM_SIGN_BIT     = 15;
   localparam int          NORM_FRAC_BITS    = 14;
   localparam int          FRAC_TIME_SHIFT   = 14;
   // fault codes
   localparam logic [7:0]  FAULT_NONE        = 8'h00;
   localparam logic [7:0]  FAULT_DATA_TYPE   = 8'h05;
   // reset value of scan time base
   localparam logic [31:0] SCAN_TIME_RESET   = 32'h0000_0001;
endpackage : pvfc_pkg

/* tb/pvfc_master_model.sv */
// fieldbus master model that issues one parameter job at a time
`timescale 1ns/1ps
module pvfc_master_model (
   // clock
   input  wire logic        mclk,
   // job towards the codec
   output logic             job_valid,
   output logic [7:0]       job_format,
   output logic [2:0]       job_value_bytes,
   output logic [31:0]      job_value,
   output logic [7:0]       param_type
);
   // idle until the first job
   initial begin
      job_valid = 1'b0;
      job_format = 8'h00;
      job_value_bytes = 3'h0;
      job_value = 32'h0000_0000;
      param_type = 8'h00;
   end
   task automatic send_job(input logic [7:0] fmt, input logic [2:0] nb, input logic [31:0] val,
                           input logic [7:0] pt);
      @(negedge mclk);
      job_valid = 1'b1;
      job_format = fmt;
      job_value_bytes = nb;
      job_value = val;
      param_type = pt;
      @(negedge mclk);
      job_valid = 1'b0;
      // value lines scrambled after the job so stale data is never trusted
      job_value = ~val;
   endtask : send_job
endmodule : pvfc_master_model

/* tb/test_param_value_format_codec.sv */
// self-checking bench for the parameter value format codec
`timescale 1ns/1ps
module test_param_value_format_codec;
   import pvfc_pkg::*;
`define CHK(nm, ex, ac) begin n_tests++; if ((ac) !== (ex)) begin errors++; $display("Error %s exp %0h got %0h", nm, ex, ac); end end
   logic        mclk, reset, job_valid, result_valid, format_ok, sign_flag;
   logic [7:0]  job_format, param_type, fault_code;
   logic [2:0]  job_value_bytes, format_length;
   logic [31:0] job_value;
   logic [15:0] norm_percent_16, packed_bool_word;
   logic [63:0] time_value;
   int          errors = 0, n_tests = 0, cycles = 0;
   // scan base Ta held at a small odd value
   logic [31:0] scan_time_base = 32'h0000_0005;
   pvfc_master_model u_master (.mclk(mclk), .job_valid(job_valid), .job_format(job_format),
      .job_value_bytes(job_value_bytes), .job_value(job_value), .param_type(param_type));
   pvfc_codec u_dut (.mclk(mclk), .reset(reset), .job_valid(job_valid), .job_format(job_format),
      .job_value_bytes(job_value_bytes), .job_value(job_value), .param_type(param_type),
      .scan_time_base(scan_time_base), .result_valid(result_valid), .format_ok(format_ok),
      .fault_code(fault_code), .format_length(format_length), .sign_flag(sign_flag),
      .norm_percent_16(norm_percent_16), .packed_bool_word(packed_bool_word), .time_value(time_value));
   // clock at 40 MHz
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // hang guard, far beyond the few dozen jobs sent
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   // one job, then the one-cycle answer and its verdict
   task automatic job(input logic [7:0] f, input logic [2:0] nb, input logic [31:0] v, input logic [7:0] pt,
                      input logic ok);
      u_master.send_job(f, nb, v, pt);
      `CHK("result_valid", 1'b1, result_valid)
      `CHK("format_ok", ok, format_ok)
      `CHK("fault_code", ok ? FAULT_NONE : FAULT_DATA_TYPE, fault_code)
   endtask : job
   // every accepted code with its byte length
   task automatic test_codes();
      logic [7:0] c [16] = '{8'h03, 8'h05, 8'h06, 8'h07, 8'h0A, 8'h0D, 8'h40, 8'h41,
                             8'h42, 8'h43, 8'h44, 8'h71, 8'h73, 8'h76, 8'h77, 8'h78};
      logic [2:0] n [16] = '{3'h2, 3'h1, 3'h2, 3'h4, 3'h1, 3'h4, 3'h0, 3'h1,
                             3'h2, 3'h4, 3'h2, 3'h2, 3'h2, 3'h2, 3'h4, 3'h2};
      for (int i = 0; i < 16; i++) begin
         job(c[i], n[i], 32'h0000_0000, c[i], 1'b1);
         `CHK("format_length", n[i], format_length)
      end
      $display("test_codes done");
   endtask : test_codes
   // percent, bit word and time constants
   task automatic test_values();
      job(FMT_NORM_PERCENT, 3'h2, 32'h0000_4000, FMT_NORM_PERCENT, 1'b1);
      `CHK("sign_flag", 1'b0, sign_flag)
      `CHK("norm_percent_16", 16'h4000, norm_percent_16)
      job(FMT_NORM_PERCENT, 3'h2, 32'h0000_C000, FMT_NORM_PERCENT, 1'b1);
      `CHK("sign_flag", 1'b1, sign_flag)
      `CHK("norm_percent_16", 16'hC000, norm_percent_16)
      job(FMT_NORM_PERCENT, 3'h2, 32'h0000_8000, FMT_NORM_PERCENT, 1'b1);
      `CHK("norm_percent_16", 16'h8000, norm_percent_16)
      job(FMT_PACKED_BOOL, 3'h2, 32'h0000_A55A, FMT_PACKED_BOOL, 1'b1);
      `CHK("packed_bool_word", 16'hA55A, packed_bool_word)
      job(FMT_INT_TIME_16, 3'h2, 32'hABCD_7FFF, FMT_INT_TIME_16, 1'b1);
      `CHK("time_value", 64'h0000_0000_0002_7FFB, time_value)
      job(FMT_FRAC_TIME, 3'h2, 32'hFFFF_4000, FMT_FRAC_TIME, 1'b1);
      `CHK("time_value", 64'h0000_0000_0000_0005, time_value)
      job(FMT_INT_TIME_32, 3'h4, 32'hFFFF_FFFF, FMT_INT_TIME_32, 1'b1);
      `CHK("time_value", 64'h0000_0004_FFFF_FFFB, time_value)
      job(FMT_TIME_DIFF, 3'h4, 32'h0000_136B, FMT_TIME_DIFF, 1'b1);
      `CHK("time_value", 64'h0000_0000_0000_6117, time_value)
      $display("test_values done");
   endtask : test_values
   // refusals leave earlier values in place
   task automatic test_refuse();
      job(8'h01, 3'h1, 32'h0000_1234, 8'h01, 1'b0);
      `CHK("format_length", 3'h0, format_length)
      job(8'h02, 3'h1, 32'h0000_1234, 8'h02, 1'b0);
      job(8'h79, 3'h2, 32'h0000_1234, 8'h79, 1'b0);
      job(8'h7C, 3'h2, 32'h0000_1234, 8'h7C, 1'b0);
      job(FMT_NORM_PERCENT, 3'h2, 32'h0000_1234, FMT_UINT16, 1'b0);
      job(FMT_PACKED_BOOL, 3'h1, 32'h0000_1234, FMT_PACKED_BOOL, 1'b0);
      job(FMT_FRAC_TIME, 3'h1, 32'h0000_7FFF, FMT_FRAC_TIME, 1'b0);
      job(FMT_FRAC_TIME, 3'h2, 32'h0000_7FFF, FMT_INT_TIME_16, 1'b0);
      `CHK("norm_percent_16", 16'h8000, norm_percent_16)
      `CHK("packed_bool_word", 16'hA55A, packed_bool_word)
      `CHK("time_value", 64'h0000_0000_0000_6117, time_value)
      $display("test_refuse done");
   endtask : test_refuse
   // reset for ten cycles, then the scenarios
   initial begin
      reset = 1'b1;
      repeat (10) @(negedge mclk);
      reset = 1'b0;
      test_codes();
      test_values();
      test_refuse();
      finish_test();
   end
endmodule : test_param_value_format_codec
